// ==== dfir_top.sv ====
// dual fir configuration, coefficient storage and per-cycle control
`timescale 1ns/1ps
`default_nettype none
module dfir_top (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // host write port
  input  wire logic [9:0] config_write_data,
  input  wire logic [8:0] config_write_addr,
  input  wire logic       config_write_n,
  // sample inputs, upper filter b bits share the low result pins
  input  wire logic [9:0] sample_in_first,
  input  wire logic       sample_in_second_lsb,
  input  wire logic [8:0] sample_in_second_upper,
  // per-clock controls
  input  wire logic [4:0] coef_set_choice,
  input  wire logic       shift_allow_n,
  input  wire logic       forward_operand_gate_n,
  input  wire logic       reverse_operand_gate_n,
  input  wire logic       lifo_swap_n,
  input  wire logic       accumulate_hold,
  input  wire logic [1:0] combiner_select,
  input  wire logic       low_drive_enable_n,
  input  wire logic       high_drive_enable_n,
  // result pins, enables low while driving
  output logic [8:0]      result_low_bits,
  output logic            result_low_oe_n,
  output logic [18:0]     result_high_bits,
  output logic            result_high_oe_n,
  output logic            result_unsigned
);
  logic [53:0] sync;
  logic        wr_s, wr_prev_q, shift_n_s, fwd_n_s, rev_n_s, swap_n_s;
  logic        acc_s, oel_s, oeh_s;
  logic [8:0]  addr_s, addr_q;
  logic [9:0]  data_s, ina_s, inb_s;
  logic [1:0]  mux_s, mux_q;
  logic [4:0]  csel_s, csel_q;
  logic [9:0]  cfg0_q, cfg1_q;
  logic [2:0]  irst_cnt_q;
  logic        irst;
  logic [9:0]  coef_q [0:255];
  logic [9:0]  ina_q, inb_q;
  logic [9:0]  fwd_q [0:1][0:3];
  logic [9:0]  rev_q [0:1][0:3];
  logic [9:0]  lifo_q [0:1][0:1];
  logic        role_q, swap_prev_q, fwd_n_q, rev_n_q, acc_q_en;
  logic [3:0]  dec_cnt_q;
  logic        adv;
  logic signed [27:0] acc_q [0:1];
  logic signed [27:0] acc_out_q [0:1];
  logic signed [27:0] tap_sum [0:1];
  logic [27:0] result_q;
  logic        wr_fall, wr_rise;

  // sign-or-zero extend a ten-bit value per its format bit
  function automatic logic signed [11:0] ext10(input logic [9:0] v,
                                               input logic       tc);
    return tc ? {{2{v[9]}}, v} : {2'b00, v};
  endfunction : ext10

  // every pin but mclk and srst passes two flops before any logic reads it
  dfir_sync #(.W(dfir_pkg::SYNC_W)) u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .pin_in   ({config_write_n, config_write_addr, config_write_data,
                shift_allow_n, forward_operand_gate_n,
                reverse_operand_gate_n, lifo_swap_n, accumulate_hold,
                combiner_select, coef_set_choice, sample_in_first,
                sample_in_second_upper, sample_in_second_lsb,
                low_drive_enable_n, high_drive_enable_n}),
    .pin_sync (sync)
  );
  assign {wr_s, addr_s, data_s, shift_n_s, fwd_n_s, rev_n_s, swap_n_s,
          acc_s, mux_s, csel_s, ina_s, inb_s, oel_s, oeh_s} = sync;

  assign wr_fall = wr_prev_q && !wr_s;
  assign wr_rise = !wr_prev_q && wr_s;

  // strobe edges; the address is held from the falling edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_prev_q <= 1'b1;
      addr_q    <= 9'h000;
    end else begin
      wr_prev_q <= wr_s;
      if (wr_fall) addr_q <= addr_s;                          // [R24]
    end
  end

  // configuration registers, written on the strobe rising edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg0_q <= dfir_pkg::CFG_RESET;
      cfg1_q <= dfir_pkg::CFG_RESET;
    end else if (wr_rise && !addr_q[dfir_pkg::COEF_SEL_BIT]) begin
      // reserved addresses 002h..0ffh are ignored
      if (addr_q == dfir_pkg::CFG0_ADDR) cfg0_q <= data_s;   // [R11] [R23]
      if (addr_q == dfir_pkg::CFG1_ADDR) cfg1_q <= data_s;   // [R11] [R23]
    end
  end

  // six-cycle datapath reset after a configuration write
  always_ff @(posedge mclk) begin
    if (srst) irst_cnt_q <= 3'h0;
    else if (wr_rise && !addr_q[dfir_pkg::COEF_SEL_BIT]
             && addr_q[8:1] == 8'h00)
      irst_cnt_q <= dfir_pkg::CFG_RST_CYC;                    // [R12]
    else if (irst_cnt_q != 3'h0) irst_cnt_q <= irst_cnt_q - 3'h1;
  end
  assign irst = srst || (irst_cnt_q != 3'h0);

  // coefficient banks: index is {filter, bank, set}; no reset, so
  // the internal reset never disturbs them
  always_ff @(posedge mclk) begin
    if (wr_rise && addr_q[dfir_pkg::COEF_SEL_BIT])            // [R22] [R23]
      coef_q[{addr_q[2], addr_q[1:0], addr_q[7:3]}] <= data_s; // [R21]
  end

  // per-clock control capture
  always_ff @(posedge mclk) begin
    if (irst) begin
      csel_q      <= 5'h00;
      mux_q       <= 2'h0;
      fwd_n_q     <= 1'b1;
      rev_n_q     <= 1'b1;
      acc_q_en    <= 1'b0;
      swap_prev_q <= 1'b1;
      role_q      <= 1'b0;
    end else begin
      csel_q      <= csel_s;                                  // [R1]
      mux_q       <= mux_s;                                   // [R9]
      fwd_n_q     <= fwd_n_s;
      rev_n_q     <= rev_n_s;
      acc_q_en    <= acc_s;
      swap_prev_q <= swap_n_s;
      if (swap_prev_q && !swap_n_s) role_q <= !role_q;        // [R7]
    end
  end

  // decimation pacing: registers advance once per n+1 shift cycles
  always_ff @(posedge mclk) begin
    if (irst) dec_cnt_q <= 4'h0;
    else if (!shift_n_s)
      dec_cnt_q <= (dec_cnt_q >= cfg0_q[3:0]) ? 4'h0
                                              : dec_cnt_q + 4'h1; // [R13]
  end
  assign adv = !shift_n_s && (dec_cnt_q == 4'h0);

  // input registers hold while shifting is disallowed
  always_ff @(posedge mclk) begin
    if (irst) begin
      ina_q <= 10'h000;
      inb_q <= 10'h000;
    end else if (!shift_n_s) begin                            // [R4]
      ina_q <= ina_s;
      inb_q <= inb_s;
    end
  end

  // forward and reverse decimation chains with lifo feedback
  always_ff @(posedge mclk) begin
    logic [9:0] tap, fb;
    if (irst) begin
      for (int f = 0; f < 2; f++) begin
        for (int k = 0; k < dfir_pkg::TAPS; k++) begin
          fwd_q[f][k] <= 10'h000;
          rev_q[f][k] <= 10'h000;
        end
        lifo_q[f][0] <= 10'h000;
        lifo_q[f][1] <= 10'h000;
      end
    end else if (adv) begin                                   // [R4]
      fwd_q[0][0] <= ina_q;
      if (!cfg0_q[dfir_pkg::C0_DUAL]) fwd_q[1][0] <= fwd_q[0][3];
      else fwd_q[1][0] <= cfg0_q[dfir_pkg::C0_SRC_B] ? inb_q
                                                     : ina_q; // [R16] [R14]
      for (int f = 0; f < 2; f++) begin
        for (int k = 1; k < dfir_pkg::TAPS; k++) begin
          fwd_q[f][k] <= fwd_q[f][k-1];
          rev_q[f][k-1] <= rev_q[f][k];
        end
        // even tap count feeds back from the last stage, odd one earlier
        tap = cfg0_q[dfir_pkg::C0_EVEN_A + f] ? fwd_q[f][3]
                                              : fwd_q[f][2];  // [R15]
        lifo_q[f][role_q] <= tap;
        fb = cfg1_q[dfir_pkg::C1_REV_OFF] ? tap : lifo_q[f][!role_q]; // [R19]
        if (f == 1 || cfg0_q[dfir_pkg::C0_DUAL]) rev_q[f][3] <= fb;
        else rev_q[f][3] <= rev_q[1][0];                      // cascade
      end
    end
  end

  // alu, multipliers and per-filter tap sum
  always_comb begin
    logic        odd, ta, tc;
    logic [4:0]  set;
    logic signed [12:0] alu;
    logic signed [11:0] a, b, c;
    odd = cfg0_q[dfir_pkg::C0_ODD_SYM];
    ta  = 1'b0;
    tc  = 1'b0;
    set = 5'h00;
    alu = 13'sh0000;
    a   = 12'sh000;
    b   = 12'sh000;
    c   = 12'sh000;
    for (int f = 0; f < 2; f++) begin
      ta = cfg1_q[2*f];
      tc = cfg1_q[2*f+1];                                     // [R18]
      // interleaved sets give filter b the neighbouring set
      set = csel_q ^ {4'h0, (f == 1) && cfg0_q[dfir_pkg::C0_INTERLEAVE]};
      tap_sum[f] = 28'sd0;
      for (int k = 0; k < dfir_pkg::TAPS; k++) begin
        a = fwd_n_q ? 12'sd0 : ext10(fwd_q[f][k], ta);        // [R5]
        b = rev_n_q ? 12'sd0 : ext10(rev_q[f][k], ta);        // [R6]
        alu = odd ? (13'(b) - 13'(a)) : (13'(b) + 13'(a));    // [R14]
        c = ext10(coef_q[{f[0], k[1:0], set}], tc);           // [R1] [R17]
        tap_sum[f] = tap_sum[f] + 28'(alu * c);
      end
    end
  end

  // accumulators: hold high keeps summing, low reloads the output
  always_ff @(posedge mclk) begin
    if (irst) begin
      for (int f = 0; f < 2; f++) begin
        acc_q[f]     <= 28'sd0;
        acc_out_q[f] <= 28'sd0;
      end
    end else begin
      for (int f = 0; f < 2; f++) begin
        acc_q[f] <= (acc_q_en ? acc_q[f] : 28'sd0) + tap_sum[f]; // [R8]
        if (!acc_q_en) acc_out_q[f] <= acc_q[f];             // [R8]
      end
    end
  end

  // combiner with rounding into the registered result
  always_ff @(posedge mclk) begin
    logic signed [27:0] sum;
    logic [3:0]         rp;
    if (irst) begin
      result_q        <= 28'h0000000;
      result_unsigned <= 1'b0;
    end else begin
      if (!cfg0_q[dfir_pkg::C0_DUAL] || mux_q == dfir_pkg::MUX_SUM ||
          mux_q == dfir_pkg::MUX_SCALED)                      // [R25]
        sum = acc_out_q[0] + ((mux_q == dfir_pkg::MUX_SCALED)
              ? (acc_out_q[1] >>> dfir_pkg::B_SCALE) : acc_out_q[1]);
      else sum = (mux_q == dfir_pkg::MUX_B) ? acc_out_q[1]
                                            : acc_out_q[0];   // [R9]
      rp = cfg1_q[8:5];
      if (!cfg1_q[dfir_pkg::C1_ROUND_OFF] && rp < 4'hc)
        sum = sum + (28'sd1 <<< (dfir_pkg::ROUND_BASE + rp)); // [R20] [R26]
      result_q <= sum;                                        // [R2]
      result_unsigned <= !cfg0_q[dfir_pkg::C0_ODD_SYM] &&
                         cfg1_q[3:0] == 4'h0;                 // [R3]
    end
  end

  // pins: enables track the host's drive enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_low_bits  <= 9'h000;
      result_high_bits <= 19'h00000;
      result_low_oe_n  <= 1'b1;
      result_high_oe_n <= 1'b1;
    end else begin
      result_low_bits  <= result_q[8:0];                      // [R2]
      result_high_bits <= result_q[27:9];
      result_low_oe_n  <= oel_s;                              // [R10]
      result_high_oe_n <= oeh_s;                              // [R10]
    end
  end

  // checks
  cfg_reset_a: assert property (@(posedge mclk) disable iff (srst) // [R12]
    $fell(irst_cnt_q == 3'h0) |-> (irst_cnt_q != 3'h0) [*6] ##1
                                  (irst_cnt_q == 3'h0))
    else $error("internal reset length wrong");
  // antecedents skip the last reset edge, where the flops still clear
  lifo_swap_a: assert property (@(posedge mclk) disable iff (irst) // [R7]
    !irst && (swap_prev_q && !swap_n_s) |=> (role_q != $past(role_q)))
    else $error("lifo roles did not swap");
  lifo_keep_a: assert property (@(posedge mclk) disable iff (irst) // [R7]
    !irst && !(swap_prev_q && !swap_n_s) |=> $stable(role_q))
    else $error("lifo roles swapped without edge");
  acc_hold_a: assert property (@(posedge mclk) disable iff (irst) // [R8]
    !irst && acc_q_en |=> $stable(acc_out_q[0]) && $stable(acc_out_q[1]))
    else $error("accumulator output moved while holding");
  in_hold_a: assert property (@(posedge mclk) disable iff (irst) // [R4]
    !irst && shift_n_s |=> $stable(ina_q) && $stable(inb_q))
    else $error("input register moved while held");
  csel_track_a: assert property (@(posedge mclk) disable iff (irst) // [R1]
    !irst |=> csel_q == $past(csel_s))
    else $error("coefficient set not taken");
  oe_track_a: assert property (@(posedge mclk) disable iff (srst) // [R10]
    ##1 1 |-> result_low_oe_n == $past(oel_s) &&
              result_high_oe_n == $past(oeh_s))
    else $error("drive enable does not follow pin");
  addr_hold_a: assert property (@(posedge mclk) disable iff (srst) // [R24]
    !wr_fall |=> $stable(addr_q))
    else $error("address moved without falling strobe");
  result_pins_a: assert property (@(posedge mclk) disable iff (srst) // [R2]
    ##1 1 |-> {result_high_bits, result_low_bits} == $past(result_q))
    else $error("result pins do not follow result");
endmodule : dfir_top
`default_nettype wire

// ==== dfir_pkg.sv ====
// constants, register layout and timing for the dual fir control block
// Behaviour
// [R1] coefficient set chosen every clock, both filters
// [R2] 28-bit registered result shares nine pins
// [R3] unsigned result only when all unsigned, even
// [R4] shift low captures samples, advances registers
// [R5] forward gate high zeroes alu a operands
// [R6] reverse gate high zeroes alu b operands
// [R7] lifo roles swap on high-to-low swap only
// [R8] accumulate high sums; low reloads output registers
// [R9] combiner select chooses combiner function each clock
// [R10] drive enables float or drive result pins
// [R11] config registers at 000h and 001h
// [R12] config write resets datapath six cycles
// [R13] reg0 bits 3:0 give decimation n+1
// [R14] reg0 bit4 dual mode, bit5 odd symmetry
// [R15] reg0 bits 6,7 even tap counts a,b
// [R16] reg0 bit8 picks filter b sample source
// [R17] reg0 bit9 selects interleaved coefficient sets
// [R18] reg1 bits 3:0 give sample/coef formats
// [R19] reg1 bit4 low enables data order reversal
// [R20] reg1 bits 8:5 round weight, bit9 disables
// [R21] 32 sets, four banks per filter
// [R22] coefficient address: a8 set, bank, filter, set
// [R23] write data captured on strobe rising edge
// [R24] write address captured on strobe falling edge
// [R25] single mode adds filters; dual mode selects
// [R26] rounding adds one at chosen weight
package dfir_pkg;
  localparam int          DATA_W        = 10;
  localparam int          ADDR_W        = 9;
  localparam int          RES_W         = 28;
  localparam int          LOW_W         = 9;
  localparam int          TAPS          = 4;
  localparam int          SETS          = 32;
  localparam int          SYNC_W        = 54;
  // register map
  localparam logic [8:0]  CFG0_ADDR     = 9'h000;
  localparam logic [8:0]  CFG1_ADDR     = 9'h001;
  localparam int          COEF_SEL_BIT  = 8;
  localparam logic [9:0]  CFG_RESET     = 10'h000;
  // register 0 fields
  localparam int          C0_DUAL       = 4;
  localparam int          C0_ODD_SYM    = 5;
  localparam int          C0_EVEN_A     = 6;
  localparam int          C0_EVEN_B     = 7;
  localparam int          C0_SRC_B      = 8;
  localparam int          C0_INTERLEAVE = 9;
  // register 1 fields
  localparam int          C1_REV_OFF    = 4;
  localparam int          C1_ROUND_OFF  = 9;
  localparam int          ROUND_BASE    = 8;   // result bit of 2^-10
  localparam int          B_SCALE       = 10;
  // internal reset after a configuration write
  localparam logic [2:0]  CFG_RST_CYC   = 3'h6;
  // combiner select codes
  localparam logic [1:0]  MUX_SCALED    = 2'h0;
  localparam logic [1:0]  MUX_SUM       = 2'h1;
  localparam logic [1:0]  MUX_A         = 2'h2;
  localparam logic [1:0]  MUX_B         = 2'h3;
endpackage : dfir_pkg

// ==== dfir_sync.sv ====
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module dfir_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q   <= '1;
      pin_sync <= '1;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule : dfir_sync
`default_nettype wire

// ==== dfir_host.sv ====
// host model: drives the asynchronous configuration and coefficient port
`timescale 1ns/1ps
`default_nettype none
module dfir_host (
  // clock used only to pace the address, data and strobe changes
  input  wire logic       mclk,
  // write port towards the device
  output logic [9:0]      config_write_data,
  output logic [8:0]      config_write_addr,
  output logic            config_write_n
);
  // idle lines show a fixed pattern or the last write inverted, never a stale value
  initial begin
    config_write_data = 10'h2aa;
    config_write_addr = 9'h155;
    config_write_n    = 1'b1;
  end

  // one write; address set up before the fall, data before the rise
  task automatic wr(input logic [8:0] addr, input logic [9:0] data);
    @(negedge mclk);
    config_write_addr = addr;
    config_write_data = data;
    repeat (4) @(negedge mclk);
    config_write_n = 1'b0;
    repeat (4) @(negedge mclk);
    config_write_n = 1'b1;
    // strobe stays high long enough before any further write
    repeat (4) @(negedge mclk);
    config_write_addr = ~addr;
    config_write_data = ~data;
  endtask : wr
endmodule : dfir_host
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the dual fir control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [9:0]  cw_data;
  logic [8:0]  cw_addr;
  logic        cw_n;
  logic [9:0]  samp_a = 10'h000;
  logic [9:0]  samp_b = 10'h000;
  logic [8:0]  samp_b_upper;
  logic [4:0]  csel = 5'h00;
  logic        shift_n = 1'b0, fwd_n = 1'b0, rev_n = 1'b1, swap_n = 1'b1;
  logic        acc_hold = 1'b0;
  logic [1:0]  mux_sel = dfir_pkg::MUX_A;
  logic        oel_n = 1'b1, oeh_n = 1'b1;
  logic [8:0]  res_lo;
  logic [18:0] res_hi;
  logic        lo_oe_n, hi_oe_n, res_uns;
  int          n_mismatch = 0;
  int          checks = 0;

  always #50 mclk = ~mclk;
  // shared pins: device drives them while its low enable is active
  assign samp_b_upper = (lo_oe_n === 1'b0) ? res_lo : samp_b[9:1];

  dfir_host u_dfir_host (.mclk(mclk), .config_write_data(cw_data),
    .config_write_addr(cw_addr), .config_write_n(cw_n));

  dfir_top u_dfir_top (.mclk(mclk), .srst(srst), .config_write_data(cw_data),
    .config_write_addr(cw_addr), .config_write_n(cw_n),
    .sample_in_first(samp_a), .sample_in_second_lsb(samp_b[0]),
    .sample_in_second_upper(samp_b_upper), .coef_set_choice(csel),
    .shift_allow_n(shift_n), .forward_operand_gate_n(fwd_n),
    .reverse_operand_gate_n(rev_n), .lifo_swap_n(swap_n),
    .accumulate_hold(acc_hold), .combiner_select(mux_sel),
    .low_drive_enable_n(oel_n), .high_drive_enable_n(oeh_n),
    .result_low_bits(res_lo), .result_low_oe_n(lo_oe_n),
    .result_high_bits(res_hi), .result_high_oe_n(hi_oe_n),
    .result_unsigned(res_uns));

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic chk_res(input logic [27:0] exp, input string msg);
    checks++;
    if ({res_hi, res_lo} !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h", $time, msg, {res_hi, res_lo});
    end
  endtask : chk_res

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk_bit

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // register pair write, then let the internal reset run out
  task automatic cfg(input logic [9:0] r0, input logic [9:0] r1);
    u_dfir_host.wr(dfir_pkg::CFG0_ADDR, r0);
    u_dfir_host.wr(dfir_pkg::CFG1_ADDR, r1);
    tick(10);
  endtask : cfg

  // same value into all four banks of one set of one filter
  task automatic coefs(input logic [4:0] set, input logic filt,
                       input logic [9:0] val);
    for (int b = 0; b < 4; b++)
      u_dfir_host.wr({1'b1, set, filt, b[1:0]}, val);
  endtask : coefs

  // bounded wait for an enable output
  task automatic wait_oe(input logic want_lo, input logic lvl);
    int k;
    for (k = 0; k < 10; k++) begin
      if ((want_lo ? lo_oe_n : hi_oe_n) === lvl)
        break;
      tick(1);
    end
    if (k == 10) begin
      n_mismatch++;
      $display("unexpected at %0t: enable timeout", $time);
      give_verdict();
    end
  endtask : wait_oe

  task automatic t_unsigned;
    logic [9:0] r0s [4] = '{10'h000, 10'h020, 10'h000, 10'h000};
    logic [9:0] r1s [4] = '{10'h200, 10'h200, 10'h201, 10'h208};
    logic       ex  [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    cfg(10'h000, 10'h200);
    u_dfir_host.wr(9'h002, 10'h3ff);
    tick(10);
    chk_bit(res_uns, 1'b1, "reserved write altered format");
    for (int k = 0; k < 4; k++) begin
      cfg(r0s[k], r1s[k]);
      chk_bit(res_uns, ex[k], "result format flag");
    end
  endtask : t_unsigned

  task automatic t_drive;
    oel_n = 1'b0;
    wait_oe(1'b1, 1'b0);
    chk_bit(hi_oe_n, 1'b1, "high pins driven early");
    oeh_n = 1'b0;
    wait_oe(1'b0, 1'b0);
    chk_bit(lo_oe_n, 1'b0, "low pins released");
  endtask : t_drive

  // dual mode, filter a only, constant sample: four equal taps
  task automatic t_filter_a;
    cfg(10'h010, 10'h200);
    coefs(5'h02, 1'b0, 10'h003);
    coefs(5'h05, 1'b0, 10'h007);
    coefs(5'h02, 1'b1, 10'h040);
    samp_a = 10'h155;
    csel = 5'h02;
    tick(30);
    chk_res(28'd4092, "filter a set 2");
    csel = 5'h05;
    tick(30);
    chk_res(28'd9548, "filter a set 5");
    samp_a = 10'h0aa;
    shift_n = 1'b1;
    tick(30);
    chk_res(28'd9548, "samples taken while held");
    shift_n = 1'b0;
    tick(30);
    chk_res(28'd4760, "new sample");
    acc_hold = 1'b1;
    csel = 5'h02;
    tick(30);
    chk_res(28'd4760, "output reg loaded while held");
    acc_hold = 1'b0;
    tick(30);
    chk_res(28'd2040, "output reg reload");
    fwd_n = 1'b1;
    tick(30);
    chk_res(28'd0, "gated operands not zero");
    fwd_n = 1'b0;
  endtask : t_filter_a

  task automatic t_round;
    cfg(10'h010, 10'h000);
    tick(30);
    chk_res(28'd2296, "round at weight 2^-10");
    cfg(10'h010, 10'h060);
    tick(30);
    chk_res(28'd4088, "round at weight 2^-7");
  endtask : t_round

  // combiner codes, interleaved sets and the single-filter sum
  task automatic t_combine;
    cfg(10'h210, 10'h200);
    mux_sel = dfir_pkg::MUX_B;
    csel = 5'h03;
    tick(30);
    chk_res(28'd43520, "interleaved set for filter b");
    cfg(10'h010, 10'h200);
    csel = 5'h02;
    mux_sel = dfir_pkg::MUX_SUM;
    tick(30);
    chk_res(28'd45560, "sum of both filters");
    mux_sel = dfir_pkg::MUX_SCALED;
    tick(30);
    chk_res(28'd2082, "filter b scaled sum");
    cfg(10'h000, 10'h200);
    mux_sel = dfir_pkg::MUX_A;
    tick(30);
    chk_res(28'd45560, "single mode sum");
  endtask : t_combine

  // reverse operands come from the draining lifo, swapped on a fall
  task automatic t_reverse;
    cfg(10'h010, 10'h200);
    mux_sel = dfir_pkg::MUX_A;
    rev_n = 1'b0;
    tick(30);
    chk_res(28'd2040, "draining lifo not empty");
    swap_n = 1'b0;
    tick(30);
    chk_res(28'd4080, "reverse operands after swap");
    fwd_n = 1'b1;
    tick(30);
    chk_res(28'd2040, "reverse operands alone");
    fwd_n = 1'b0;
    rev_n = 1'b1;
    swap_n = 1'b1;
  endtask : t_reverse

  // filter b via its own pins; low pins float so only high bits count
  task automatic t_filter_b;
    oel_n = 1'b1;
    mux_sel = dfir_pkg::MUX_B;
    samp_b = 10'h100;
    cfg(10'h110, 10'h200);
    wait_oe(1'b1, 1'b1);
    tick(30);
    checks++;
    if (res_hi !== 19'd128) begin
      n_mismatch++;
      $display("unexpected at %0t: filter b own input", $time);
    end
    cfg(10'h010, 10'h200);
    tick(30);
    checks++;
    if (res_hi !== 19'd85) begin
      n_mismatch++;
      $display("unexpected at %0t: filter b from first input", $time);
    end
  endtask : t_filter_b

  initial begin
    tick(2);
    chk_res(28'h0000000, "result during reset");
    chk_bit(lo_oe_n, 1'b1, "low enable during reset");
    chk_bit(hi_oe_n, 1'b1, "high enable during reset");
    tick(1);
    srst = 1'b0;
    tick(3);
    t_unsigned();
    t_drive();
    t_filter_a();
    t_round();
    t_combine();
    t_reverse();
    t_filter_b();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
